//--- verilog/ccsm_pkg.sv
// Constants, register map and helpers for the cyclic control/status mapper.
// Assumes a single 125 MHz system clock shared by all users of the package.
package ccsm_pkg;
  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 125000000;
  localparam int unsigned FLASH_HALF_MS  = 500;
  localparam int unsigned FLICK_HALF_MS  = 50;
  localparam int unsigned FLASH_CYCLES   = FLASH_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned FLICK_CYCLES   = FLICK_HALF_MS * (CLK_HZ / 1000);

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] ADR_CTRL_WORD  = 8'h00;
  localparam logic [7:0] ADR_WRITE_SEL  = 8'h04;
  localparam logic [7:0] ADR_WRITE_VAL  = 8'h08;
  localparam logic [7:0] ADR_READ_SEL0  = 8'h0c;
  localparam logic [7:0] ADR_COMMIT     = 8'h1c;
  localparam logic [7:0] ADR_STATUS     = 8'h20;
  localparam logic [7:0] ADR_VALUE0     = 8'h24;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h34;
  localparam logic [7:0] ADR_IRQ_MASK   = 8'h38;
  localparam int unsigned NUM_READ      = 4;

  // ****************************************************************
  // Inbound control word fields
  // ****************************************************************
  localparam int unsigned CW_START     = 0;
  localparam int unsigned CW_FREEZE    = 1;
  localparam int unsigned CW_RESET     = 2;
  localparam int unsigned CW_EXT_TRIP  = 3;
  localparam int unsigned CW_NET_CTRL  = 4;
  localparam logic [15:0] CW_USED_MASK = 16'h001f;

  // ****************************************************************
  // Outbound status word fields
  // ****************************************************************
  localparam int unsigned ST_FAULT     = 0;
  localparam int unsigned ST_RUNNING   = 1;
  localparam int unsigned ST_END_START = 2;
  localparam int unsigned ST_CUR_LIMIT = 3;
  localparam int unsigned ST_ENERGY    = 4;
  localparam int unsigned ST_STOPPING  = 5;
  localparam int unsigned ST_NET_CTRL  = 6;
  localparam int unsigned ST_CODE_LSB  = 16;

  // ****************************************************************
  // Interrupt events and parameter widths
  // ****************************************************************
  localparam int unsigned EV_TRIP   = 0;
  localparam int unsigned EV_WRITE  = 1;
  localparam int unsigned EV_NETCTL = 2;
  localparam int unsigned EV_COUNT  = 3;

  localparam logic [1:0] PW_8  = 2'h0;
  localparam logic [1:0] PW_16 = 2'h1;
  localparam logic [1:0] PW_32 = 2'h2;
  localparam logic [1:0] PW_64 = 2'h3;

  typedef enum logic [2:0] {
    LED_OFF, LED_A_ON, LED_A_BLINK, LED_B_ON, LED_B_BLINK
  } ccsm_led_type;

  // Keep least significant part only, zero above the parameter width
  function automatic logic [31:0] ccsm_trunc(input logic [63:0] v,
                                             input logic [1:0]  w);
    case (w)
      PW_8:    ccsm_trunc = {24'h000000, v[7:0]};
      PW_16:   ccsm_trunc = {16'h0000, v[15:0]};
      default: ccsm_trunc = v[31:0];
    endcase
  endfunction
endpackage

//--- verilog/ccsm_rd_if.sv
// Read selector and returned value bundle between mapper and sequencer.
// Assumes both ends run on clk_sys.
`timescale 1ns/10ps
interface ccsm_rd_if;
  logic [3:0][15:0] sel;
  logic [3:0][31:0] val;
  modport top (output sel, input val);
  modport seq (input sel, output val);
endinterface

//--- verilog/ccsm_led.sv
// Two-colour indicator driver from a mode and a blink phase.
// Assumes the phase input is a slow level from a divider on clk_sys.
`timescale 1ns/10ps
module ccsm_led
  import ccsm_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire ccsm_led_type mode,
  input  wire logic         phase,
  output logic              color_a,
  output logic              color_b
);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      color_a <= 1'b0;
      color_b <= 1'b0;
    end else begin
      color_a <= (mode == LED_A_ON) || ((mode == LED_A_BLINK) && phase);
      color_b <= (mode == LED_B_ON) || ((mode == LED_B_BLINK) && phase);
    end
  end
endmodule // ccsm_led

//--- verilog/ccsm_rd_seq.sv
// Round-robin fetch of the four selected parameters from the store.
// Assumes the store answers data and width one cycle after the number.
`timescale 1ns/10ps
module ccsm_rd_seq
  import ccsm_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rst,
  ccsm_rd_if.seq      rd,
  output logic [15:0] par_rd_num,
  input  wire logic [63:0] par_rd_data,
  input  wire logic [1:0]  par_rd_width
);
  typedef enum {SEQ_ISSUE, SEQ_TAKE} ccsm_seq_type;
  ccsm_seq_type state;
  logic [1:0]   idx;

  assign par_rd_num = rd.sel[idx];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state  <= SEQ_ISSUE;
      idx    <= 2'h0;
      rd.val <= '0;
    end else begin
      case (state)
        SEQ_ISSUE: state <= SEQ_TAKE;
        SEQ_TAKE: begin
          // Zero selector returns zero whatever the store says
          if (rd.sel[idx] == 16'h0000) begin
            rd.val[idx] <= 32'h00000000;
          end else begin
            rd.val[idx] <= ccsm_trunc(par_rd_data, par_rd_width);
          end
          idx   <= idx + 2'h1;
          state <= SEQ_ISSUE;
        end
        default: state <= SEQ_ISSUE;
      endcase
    end
  end
endmodule // ccsm_rd_seq

//--- verilog/ccsm_top.sv
// Cyclic control/status mapper: decodes the inbound frame, builds the
// outbound frame and drives the front indicators.
// Assumes the network stack writes frames over classic Wishbone, and the
// motor core and parameter store share clk_sys.
//
// Functional notes
// - Control word: start, freeze, reset, trip, netctl
// - Bits 0..3 act only with netctl set
// - Word 2 selects parameter, word 3 value
// - Zero write selector performs no assignment
// - Narrow target keeps low part of value
// - Words 4..7 select returns; zero gives 0
// - Answer five 32-bit words on assembly 100
// - Status bits 0..6, trip code above
// - Trip code present only while tripped
// - Returned words follow selectors in order
// - Returned values zero-extended or truncated to 32
// - Network indicator from address and connection state
// - Module indicator from run and fault state
// - Port link colour by speed, flicker on activity
`timescale 1ns/10ps
module ccsm_top
  import ccsm_pkg::*;
#(
  parameter int unsigned FLASH_HALF = FLASH_CYCLES,
  parameter int unsigned FLICK_HALF = FLICK_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq,
  output logic             cmd_start,
  output logic             cmd_freeze,
  output logic             cmd_reset,
  output logic             cmd_ext_trip,
  output logic             net_control,
  input  wire logic        mc_fault,
  input  wire logic        mc_running,
  input  wire logic        mc_end_start,
  input  wire logic        mc_cur_limit,
  input  wire logic        mc_energy_recovery,
  input  wire logic        mc_stopping,
  input  wire logic [15:0] mc_trip_code,
  output logic             par_wr_stb,
  output logic [15:0]      par_wr_num,
  output logic [31:0]      par_wr_data,
  input  wire logic [1:0]  par_wr_width,
  output logic [15:0]      par_rd_num,
  input  wire logic [63:0] par_rd_data,
  input  wire logic [1:0]  par_rd_width,
  input  wire logic        nw_ip_valid,
  input  wire logic        nw_conn_active,
  input  wire logic        nw_fatal,
  input  wire logic        nw_conn_timeout,
  input  wire logic        md_run,
  input  wire logic        md_major_fault,
  input  wire logic        md_recoverable,
  input  wire logic [1:0]  phy_link_up,
  input  wire logic [1:0]  phy_speed_100,
  input  wire logic [1:0]  phy_activity,
  output logic             net_led_green,
  output logic             net_led_red,
  output logic             mod_led_green,
  output logic             mod_led_red,
  output logic [1:0]       link_led_green,
  output logic [1:0]       link_led_yellow
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  ccsm_rd_if          rd ();
  logic [15:0]        ctrl_word;
  logic [15:0]        write_sel;
  logic [31:0]        write_val;
  logic [3:0][15:0]   read_sel;
  logic [31:0]        status_word;
  logic [EV_COUNT-1:0] irq_status, irq_mask, events;
  logic               commit, fault_q, req, wr;
  logic [31:0]        next_rdata;
  logic [31:0]        flash_cnt, flick_cnt;
  logic               flash_phase, flick_phase;
  logic [1:0]         link_s1, link_s2, spd_s1, spd_s2, act_s1, act_s2;
  ccsm_led_type       net_mode, mod_mode;
  ccsm_led_type       link_mode [2];

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] lane(input logic [31:0] old,
                                       input logic [31:0] nw,
                                       input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      lane[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  // Single-cycle answer; ack drops the cycle after it was given
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i;

  always_comb begin
    next_rdata = 32'h00000000;
    case (wb_adr_i)
      ADR_CTRL_WORD:  next_rdata = {16'h0000, ctrl_word};
      ADR_WRITE_SEL:  next_rdata = {16'h0000, write_sel};
      ADR_WRITE_VAL:  next_rdata = write_val;
      ADR_STATUS:     next_rdata = status_word;
      ADR_IRQ_STATUS: next_rdata = {{(32-EV_COUNT){1'b0}}, irq_status};
      ADR_IRQ_MASK:   next_rdata = {{(32-EV_COUNT){1'b0}}, irq_mask};
      default: begin
        for (int i = 0; i < NUM_READ; i++) begin
          if (wb_adr_i == ADR_READ_SEL0 + 8'(4 * i)) begin
            next_rdata = {16'h0000, read_sel[i]};
          end
          if (wb_adr_i == ADR_VALUE0 + 8'(4 * i)) begin
            next_rdata = rd.val[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // Inbound frame registers
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {ctrl_word, write_sel, write_val} <= 64'h0000000000000000;
      read_sel  <= '0;
    end else if (wr) begin
      if (wb_adr_i == ADR_CTRL_WORD) begin
        ctrl_word <= 16'(lane({16'h0000, ctrl_word}, wb_dat_i, wb_sel_i))
                     & CW_USED_MASK;
      end
      if (wb_adr_i == ADR_WRITE_SEL) begin
        write_sel <= 16'(lane({16'h0000, write_sel}, wb_dat_i,
                              wb_sel_i));
      end
      if (wb_adr_i == ADR_WRITE_VAL) begin
        write_val <= lane(write_val, wb_dat_i, wb_sel_i);
      end
      for (int i = 0; i < NUM_READ; i++) begin
        if (wb_adr_i == ADR_READ_SEL0 + 8'(4 * i)) begin
          read_sel[i] <= 16'(lane({16'h0000, read_sel[i]}, wb_dat_i,
                                  wb_sel_i));
        end
      end
    end
  end

  assign rd.sel = read_sel;
  // One write to the commit word applies the frame once
  assign commit = wr && (wb_adr_i == ADR_COMMIT) && wb_sel_i[0]
                  && wb_dat_i[0];

  // ****************************************************************
  // Motor commands
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {net_control, cmd_ext_trip, cmd_reset, cmd_freeze, cmd_start} <= 5'h00;
    end else begin
      net_control  <= ctrl_word[CW_NET_CTRL];
      // Without network control the four command bits are masked
      {cmd_ext_trip, cmd_reset, cmd_freeze, cmd_start} <=
        ctrl_word[CW_EXT_TRIP:CW_START] & {4{ctrl_word[CW_NET_CTRL]}};
    end
  end

  // ****************************************************************
  // Parameter write
  // ****************************************************************
  assign par_wr_num = write_sel;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      par_wr_stb  <= 1'b0;
      par_wr_data <= 32'h00000000;
    end else begin
      par_wr_stb <= commit && (write_sel != 16'h0000);
      if (commit) begin
        par_wr_data <= ccsm_trunc({32'h00000000, write_val},
                                  par_wr_width);
      end
    end
  end

  // ****************************************************************
  // Selected parameter reads
  // ****************************************************************
  ccsm_rd_seq u_rd_seq (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .rd           (rd.seq),
    .par_rd_num   (par_rd_num),
    .par_rd_data  (par_rd_data),
    .par_rd_width (par_rd_width)
  );

  // ****************************************************************
  // Outbound status word
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_word <= 32'h00000000;
    end else begin
      status_word              <= 32'h00000000;
      status_word[ST_FAULT]     <= mc_fault;
      status_word[ST_RUNNING]   <= mc_running;
      status_word[ST_END_START] <= mc_end_start;
      status_word[ST_CUR_LIMIT] <= mc_cur_limit;
      status_word[ST_ENERGY]    <= mc_energy_recovery;
      status_word[ST_STOPPING]  <= mc_stopping;
      status_word[ST_NET_CTRL]  <= ctrl_word[CW_NET_CTRL];
      // Code is meaningless while healthy, so it is held at zero
      if (mc_fault) begin
        status_word[ST_CODE_LSB +: 16] <= mc_trip_code;
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always_comb begin
    events            = '0;
    events[EV_TRIP]   = mc_fault && !fault_q;
    events[EV_WRITE]  = commit && (write_sel != 16'h0000);
    events[EV_NETCTL] = net_control != ctrl_word[CW_NET_CTRL];
  end

  // A new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_q    <= 1'b0;
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      fault_q <= mc_fault;
      if (wr && wb_adr_i == ADR_IRQ_STATUS && wb_sel_i[0]) begin
        irq_status <= (irq_status & ~wb_dat_i[EV_COUNT-1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
      if (wr && wb_adr_i == ADR_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask <= wb_dat_i[EV_COUNT-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************************************
  // Indicator timing
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {flash_cnt, flick_cnt}     <= 64'h0000000000000000;
      {flash_phase, flick_phase} <= 2'b00;
    end else begin
      if (flash_cnt >= 32'(FLASH_HALF - 1)) begin
        flash_cnt   <= 32'h00000000;
        flash_phase <= !flash_phase;
      end else begin
        flash_cnt <= flash_cnt + 32'h00000001;
      end
      if (flick_cnt >= 32'(FLICK_HALF - 1)) begin
        flick_cnt   <= 32'h00000000;
        flick_phase <= !flick_phase;
      end else begin
        flick_cnt <= flick_cnt + 32'h00000001;
      end
    end
  end

  // PHY status pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {link_s1, link_s2, spd_s1, spd_s2, act_s1, act_s2} <= 12'h000;
    end else begin
      {link_s2, link_s1} <= {link_s1, phy_link_up};
      {spd_s2, spd_s1}   <= {spd_s1, phy_speed_100};
      {act_s2, act_s1}   <= {act_s1, phy_activity};
    end
  end

  // ****************************************************************
  // Indicator modes
  // ****************************************************************
  always_comb begin
    // Fatal outranks timeout; no address blanks the rest
    if (nw_fatal) begin
      net_mode = LED_B_ON;
    end else if (nw_conn_timeout) begin
      net_mode = LED_B_BLINK;
    end else if (!nw_ip_valid) begin
      net_mode = LED_OFF;
    end else if (nw_conn_active) begin
      net_mode = LED_A_ON;
    end else begin
      net_mode = LED_A_BLINK;
    end
    // Off without power needs no logic
    if (md_major_fault) begin
      mod_mode = LED_B_ON;
    end else if (md_recoverable) begin
      mod_mode = LED_B_BLINK;
    end else if (md_run) begin
      mod_mode = LED_A_ON;
    end else begin
      mod_mode = LED_A_BLINK;
    end
    for (int p = 0; p < 2; p++) begin
      if (!link_s2[p]) begin
        link_mode[p] = LED_OFF;
      end else if (spd_s2[p]) begin
        link_mode[p] = act_s2[p] ? LED_A_BLINK : LED_A_ON;
      end else begin
        link_mode[p] = act_s2[p] ? LED_B_BLINK : LED_B_ON;
      end
    end
  end

  ccsm_led u_net_led (
    .clk_sys (clk_sys),
    .rst     (rst),
    .mode    (net_mode),
    .phase   (flash_phase),
    .color_a (net_led_green),
    .color_b (net_led_red)
  );

  ccsm_led u_mod_led (
    .clk_sys (clk_sys),
    .rst     (rst),
    .mode    (mod_mode),
    .phase   (flash_phase),
    .color_a (mod_led_green),
    .color_b (mod_led_red)
  );

  for (genvar p = 0; p < 2; p++) begin : g_link
    ccsm_led u_link_led (
      .clk_sys (clk_sys),
      .rst     (rst),
      .mode    (link_mode[p]),
      .phase   (flick_phase),
      .color_a (link_led_green[p]),
      .color_b (link_led_yellow[p])
    );
  end
endmodule // ccsm_top

//--- verification/ccsm_store_model.sv
// Behavioural parameter store beside the mapper.
// Assumes reads answer one cycle after the number.
`timescale 1ns/10ps
module ccsm_store_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] par_rd_num,
  output logic      [63:0] par_rd_data,
  output logic      [1:0]  par_rd_width,
  input  wire logic        par_wr_stb,
  input  wire logic [15:0] par_wr_num,
  input  wire logic [31:0] par_wr_data,
  output logic      [1:0]  par_wr_width
);
  logic [15:0] wr_num;
  logic [31:0] wr_data;
  int          wr_cnt = 0;
  // Low number bits pick the width, so every width code is reachable
  assign par_wr_width = par_wr_num[1:0];
  always @(posedge clk_sys) begin
    // Upper word differs so a missing truncation shows
    par_rd_data  <= {par_rd_num, ~par_rd_num,
                     par_rd_num ^ 16'h3c3c, ~par_rd_num};
    par_rd_width <= par_rd_num[1:0];
    if (par_wr_stb) begin
      wr_num  <= par_wr_num;
      wr_data <= par_wr_data;
      wr_cnt  <= wr_cnt + 1;
    end
  end
endmodule // ccsm_store_model

//--- verification/ccsm_props.sv
// Checker on the mapper ports.
// Assumes it is bound into the mapper top.
`timescale 1ns/10ps
module ccsm_props
  import ccsm_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic        cmd_start,
  input wire logic        cmd_freeze,
  input wire logic        cmd_reset,
  input wire logic        cmd_ext_trip,
  input wire logic        net_control,
  input wire logic        par_wr_stb,
  input wire logic [15:0] par_wr_num,
  input wire logic [31:0] par_wr_data,
  input wire logic [1:0]  par_wr_width,
  input wire logic        nw_fatal,
  input wire logic        net_led_red,
  input wire logic        net_led_green
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence commit_s;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == ADR_COMMIT;
  endsequence
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing");
  AST_CMD_GATE: assert property ((cmd_start || cmd_freeze || cmd_reset ||
    cmd_ext_trip) |-> net_control) else $error("command without netctl");
  AST_WR_CAUSE: assert property (par_wr_stb |-> par_wr_num != 16'h0000
    && wb_ack_o && wb_we_i && wb_adr_i == ADR_COMMIT)
    else $error("stray write");
  AST_WR_ZERO: assert property (commit_s ##0 par_wr_num == 16'h0000
    |-> !par_wr_stb [*2]) else $error("write with zero select");
  AST_WR_TRUNC: assert property (par_wr_stb |->
    (par_wr_width == PW_8 ? par_wr_data[31:8] == 24'h000000 :
     par_wr_width == PW_16 ? par_wr_data[31:16] == 16'h0000 : 1'b1))
    else $error("write value not truncated");
  AST_WR_PULSE: assert property (par_wr_stb |=> !par_wr_stb)
    else $error("write strobe held");
  AST_NET_RED: assert property (nw_fatal [*2] |=>
    net_led_red && !net_led_green) else $error("fatal not steady red");
endmodule // ccsm_props

//--- verification/ccsm_top_test.sv
// Self-checking bench for the cyclic control/status mapper.
// Assumes the store model answers reads one cycle late.
`timescale 1ns/10ps
module ccsm_top_test
  import ccsm_pkg::*;
;
  logic        clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic        cmd_start, cmd_freeze, cmd_reset, cmd_ext_trip, net_control;
  logic        mc_fault, mc_running, mc_end_start, mc_cur_limit;
  logic        mc_energy_recovery, mc_stopping, par_wr_stb, nw_ip_valid;
  logic        nw_conn_active, nw_fatal, nw_conn_timeout, md_run;
  logic        md_major_fault, md_recoverable, net_led_green, net_led_red;
  logic        mod_led_green, mod_led_red;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, par_wr_data, rd, v;
  logic [15:0] mc_trip_code, par_wr_num, par_rd_num, cw, n, sn [4];
  logic [63:0] par_rd_data;
  logic [1:0]  par_wr_width, par_rd_width, phy_link_up, phy_speed_100;
  logic [1:0]  phy_activity, link_led_green, link_led_yellow;
  logic [5:0]  m, any1, all1;
  integer      seed = 32'h78e821e5;
  int          miscompares = 0, n_checks = 0, c0;
  ccsm_top #(.FLASH_HALF(4), .FLICK_HALF(2)) i_dut (.*);
  ccsm_store_model i_store (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] fit(input logic [31:0] d,
                                      input logic [15:0] k);
    fit = (k[1:0] == PW_8) ? {24'h000000, d[7:0]} :
          (k[1:0] == PW_16) ? {16'h0000, d[15:0]} : d;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hf};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 40);
    rd = wb_dat_o;
    if (t == 40) miscompares++;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic led(input logic [9:0] in, input logic [5:0] ea, ee);
    @(posedge clk_sys);
    {nw_ip_valid, nw_conn_active, nw_fatal, nw_conn_timeout, md_run,
     md_major_fault, md_recoverable} <= in[9:3];
    {phy_link_up, phy_speed_100, phy_activity} <=
      {{2{in[2]}}, {2{in[1]}}, {2{in[0]}}};
    idle(10);
    {any1, all1} = 12'h03f;
    repeat (32) begin
      @(negedge clk_sys);
      m = {net_led_green, net_led_red, mod_led_green, mod_led_red,
           link_led_green[0], link_led_yellow[0]};
      any1 = any1 | m;
      all1 = all1 & m;
    end
    chk({any1, all1}, {ea, ee});
  endtask
  task automatic final_report();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    final_report();
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i} = 17'h10000;
    {wb_dat_i, mc_trip_code, m} = 54'h0;
    {mc_fault, mc_running, mc_end_start, mc_cur_limit} = 4'h0;
    {mc_energy_recovery, mc_stopping} = 2'b00;
    {phy_link_up, phy_speed_100, phy_activity} = 6'h00;
    {nw_ip_valid, nw_conn_active, nw_fatal, nw_conn_timeout} = 4'h0;
    {md_run, md_major_fault, md_recoverable} = 3'h0;
    idle(5);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      v = $random(seed);
      cw = (i == 0) ? 16'hffef : (i == 1) ? 16'hffff : v[15:0];
      wb(1'b1, ADR_CTRL_WORD, {16'h0000, cw});
      idle(3);
      chk({net_control, cmd_ext_trip, cmd_reset, cmd_freeze, cmd_start},
          {cw[4], cw[4] ? cw[3:0] : 4'h0});
      wb(1'b0, ADR_CTRL_WORD, 32'h0);
      chk(rd, {16'h0000, cw & CW_USED_MASK});
    end
    $display("control word test done");
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      m = (i == 0) ? 6'h00 : v[5:0];
      @(posedge clk_sys);
      {mc_fault, mc_running, mc_end_start, mc_cur_limit,
       mc_energy_recovery, mc_stopping} <= m;
      mc_trip_code <= v[31:16];
      idle(3);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(rd, {m[5] ? v[31:16] : 16'h0000, 9'h000, cw[4], m[0], m[1],
               m[2], m[3], m[4], m[5]});
    end
    $display("status test done");
    wb(1'b1, ADR_IRQ_STATUS, 32'h7);
    wb(1'b1, ADR_IRQ_MASK, 32'h2);
    for (int i = 0; i < 5; i++) begin
      v = $random(seed);
      n = (i == 0) ? 16'h0000 : {v[15:3], 1'b1, 2'(i - 1)};
      c0 = i_store.wr_cnt;
      wb(1'b1, ADR_WRITE_SEL, {16'h0000, n});
      v = $random(seed);
      wb(1'b1, ADR_WRITE_VAL, v);
      wb(1'b1, ADR_COMMIT, 32'h1);
      idle(3);
      chk(i_store.wr_cnt - c0, n != 16'h0000);
      if (n != 16'h0000) chk(i_store.wr_data, fit(v, n));
      if (n != 16'h0000) chk(i_store.wr_num, n);
    end
    chk(irq, 1'b1);
    wb(1'b1, ADR_IRQ_STATUS, 32'h7);
    idle(1);
    chk(irq, 1'b0);
    wb(1'b1, ADR_IRQ_MASK, 32'h0);
    wb(1'b1, ADR_COMMIT, 32'h1);
    idle(2);
    chk(irq, 1'b0);
    wb(1'b0, ADR_IRQ_STATUS, 32'h0);
    chk(rd, 32'h2);
    wb(1'b1, 8'hfc, 32'hffffffff);
    wb(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    $display("parameter write test done");
    for (int i = 0; i < NUM_READ; i++) begin
      v = $random(seed);
      sn[i] = (i == 2) ? 16'h0000 : v[15:0];
      wb(1'b1, ADR_READ_SEL0 + 8'(4 * i), {16'h0000, sn[i]});
    end
    idle(24);
    for (int i = 0; i < NUM_READ; i++) begin
      wb(1'b0, ADR_VALUE0 + 8'(4 * i), 32'h0);
      chk(rd, sn[i] == 16'h0000 ? 32'h0 :
          fit({sn[i] ^ 16'h3c3c, ~sn[i]}, sn[i]));
    end
    $display("parameter read test done");
    led(10'b1110010110, 6'b010110, 6'b010110);
    led(10'b0000001100, 6'b000101, 6'b000001);
    led(10'b1100100111, 6'b101010, 6'b101000);
    led(10'b1000000000, 6'b101000, 6'b000000);
    led(10'b1101101101, 6'b010101, 6'b000000);
    $display("indicator test done");
    final_report();
  end
endmodule // ccsm_top_test
bind ccsm_top ccsm_props i_props (.*);
